//--- rtl/opm_ctrl.sv
// operating mode, oscillator gating and wake control
// Summary of operation
// - after reset start in normal, fast clock
// - slow select one picks slow rc clock
// - slow mode alone never halts fast oscillator
// - slow instruction clock uses shared divider option
// - powerdown request halts execution
// - powerdown stops all oscillators and peripherals
// - powerdown wake clears powerdown request
// - powerdown wake always returns to normal
// - fast halt in normal acts as powerdown
// - green request halts cpu, clock stays
// - green wake clears green request
// - green wake returns to prior mode
// - basic timer overflow or port1 wakes green
// - pwm runs in green, ext timers no wake
// - timers and adc run only when enabled
// - crystal option waits 2048 fast clocks
// - rc options wait 32 fast clocks
// - green wake has no warm-up
// - write-only port1 wake enable, reset zero
// - either edge on enabled pin wakes
// - rtc option keeps crystal while fast halted
// - mode field: normal, powerdown, green, reserved
// - fast halt in slow mode stops fast osc, slow runs
`timescale 1ns/1ns
`include "opm_regs.svh"

module opm_ctrl
  import opm_pkg::*;
#(
  parameter opm_osc_kind_type OSC_KIND  = OPM_OSC_XTAL, // build option
  parameter logic [7:0]       DIV_SEL   = 8'h04         // 1..128 prescale
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // wake sources and boundary
  input  wire logic [7:0]  port1_pins,
  input  wire logic        basic_timer_ovf,
  input  wire logic        insn_boundary,
  input  wire logic        fast_ticks,
  // controls out
  output logic             fast_osc_en,
  output logic             rtc_xtal_en,
  output logic             slow_osc_en,
  output logic [1:0]       sysclk_sel,
  output logic             cpu_run,
  output logic             insn_tick,
  output logic             basic_timer_en,
  output logic             ext_timer_zero_en,
  output logic             adc_en,
  output logic             pwm_en
);

  // ==========================================================
  // register state
  logic [7:0]    port1_wake_enable_reg; // write only, steers wake
  logic          fast_osc_halt_reg;
  logic          slow_clock_select_reg;
  logic          powerdown_request_reg;
  logic          green_request_reg;
  logic [2:0]    timer_ctrl_reg;        // basic, ext0, adc run bits
  opm_state_type state_reg;             // mode controller
  logic          green_from_slow_reg;   // mode to return to
  logic [11:0]   warm_cnt_reg;          // warm-up counter
  logic [7:0]    port1_prev_reg;        // last pin sample
  logic [7:0]    div_cnt_reg;           // shared prescaler

  // bus handshake state
  logic          aw_held_reg;
  logic          w_held_reg;
  logic [7:0]    aw_addr_reg;
  logic [31:0]   w_data_reg;
  logic          w_lane0_reg;

  // ==========================================================
  // decode helpers
  function automatic logic is_idle(input opm_state_type s);
    is_idle = (s == OPM_ST_PDOWN) || (s == OPM_ST_GREEN) ||
              (s == OPM_ST_HALT);
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `OPM_PORT1_WAKE_ENABLE_ADDR) ||
               (a == `OPM_OSC_MODE_ADDR) ||
               (a == `OPM_STATUS_ADDR) ||
               (a == `OPM_TIMER_CTRL_ADDR);
  endfunction

  // ==========================================================
  // wake detection
  logic [7:0] pin_change;
  logic       port1_wake;
  logic       wake_any;
  logic       do_write;
  logic [11:0] warm_target;

  // either edge on an enabled pin
  assign pin_change = (port1_pins ^ port1_prev_reg) &
                      port1_wake_enable_reg;
  assign port1_wake = |pin_change;
  // basic timer wakes green only, extended timers are not wired in
  assign wake_any   = port1_wake ||
                      ((state_reg == OPM_ST_GREEN) && basic_timer_ovf &&
                       timer_ctrl_reg[`OPM_BT_RUN_BIT]);
  // crystal vs rc warm-up length
  assign warm_target = (OSC_KIND == OPM_OSC_XTAL) ?
                       `OPM_WARM_XTAL : `OPM_WARM_RC;

  // a write lands when both halves are held and response slot is free
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // ==========================================================
  // pin history, kept even while idle so a change is seen
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port1_prev_reg <= 8'h00;
    end else begin
      port1_prev_reg <= port1_pins;
    end
  end

  // ==========================================================
  // axi write address and data capture, any order
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_lane0_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // ready is a one-cycle pulse on acceptance
      s_axi_awready <= s_axi_awvalid && !aw_held_reg && !s_axi_awready;
      s_axi_wready  <= s_axi_wvalid && !w_held_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // write response, decerr on unmapped address
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_hit(aw_addr_reg) ? 2'b00 : 2'b11;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // port1 wake enable and timer control registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port1_wake_enable_reg <= `OPM_P1W_RESET;
      timer_ctrl_reg        <= 3'b000;
    end else if (do_write && w_lane0_reg) begin
      if (aw_addr_reg == `OPM_PORT1_WAKE_ENABLE_ADDR) begin
        port1_wake_enable_reg <= w_data_reg[7:0];
      end
      if (aw_addr_reg == `OPM_TIMER_CTRL_ADDR) begin
        timer_ctrl_reg <= w_data_reg[2:0];
      end
    end
  end

  // ==========================================================
  // oscillator mode register: software writes, hardware clears
  // the idle requests on wake; writes arriving while idle are dropped
  logic osc_wr;
  assign osc_wr = do_write && w_lane0_reg &&
                  (aw_addr_reg == `OPM_OSC_MODE_ADDR);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fast_osc_halt_reg     <= 1'b0;
      slow_clock_select_reg <= 1'b0;
      powerdown_request_reg <= 1'b0;
      green_request_reg     <= 1'b0;
    end else begin
      if (osc_wr && !is_idle(state_reg)) begin
        fast_osc_halt_reg     <= w_data_reg[`OPM_FAST_HALT_BIT];
        slow_clock_select_reg <= w_data_reg[`OPM_SLOW_SEL_BIT];
        powerdown_request_reg <= w_data_reg[`OPM_PD_REQ_BIT];
        green_request_reg     <= w_data_reg[`OPM_GREEN_REQ_BIT];
      end else if (is_idle(state_reg) && wake_any) begin
        if (state_reg != OPM_ST_GREEN) begin
          powerdown_request_reg <= 1'b0;
          slow_clock_select_reg <= 1'b0;
          fast_osc_halt_reg     <= 1'b0;
        end else begin
          green_request_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // mode controller; requests act only at an instruction boundary
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg           <= OPM_ST_NORMAL;
      green_from_slow_reg <= 1'b0;
      warm_cnt_reg        <= 12'h000;
    end else begin
      unique case (state_reg)
        OPM_ST_NORMAL, OPM_ST_SLOW: begin
          if (insn_boundary && !osc_wr) begin
            if (powerdown_request_reg) begin
              state_reg <= OPM_ST_PDOWN;
            end else if (green_request_reg) begin
              green_from_slow_reg <= (state_reg == OPM_ST_SLOW);
              state_reg <= OPM_ST_GREEN;
            end else if (fast_osc_halt_reg &&
                         !slow_clock_select_reg) begin
              state_reg <= OPM_ST_HALT;
            end else if (slow_clock_select_reg) begin
              state_reg <= OPM_ST_SLOW;
            end else begin
              state_reg <= OPM_ST_NORMAL;
            end
          end
        end
        OPM_ST_PDOWN, OPM_ST_HALT: begin
          if (wake_any) begin
            warm_cnt_reg <= 12'h000;
            state_reg    <= OPM_ST_WARM;
          end
        end
        OPM_ST_WARM: begin
          if (fast_ticks) begin
            if (warm_cnt_reg == warm_target - 12'h001) begin
              state_reg <= OPM_ST_NORMAL;
            end else begin
              warm_cnt_reg <= warm_cnt_reg + 12'h001;
            end
          end
        end
        OPM_ST_GREEN: begin
          if (wake_any) begin
            state_reg <= green_from_slow_reg ?
                         OPM_ST_SLOW : OPM_ST_NORMAL;
          end
        end
        default: begin
          state_reg <= OPM_ST_NORMAL;
        end
      endcase
    end
  end

  // ==========================================================
  // shared prescaler: one instruction tick per DIV_SEL source clocks
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_cnt_reg <= 8'h00;
      insn_tick   <= 1'b0;
    end else if (cpu_run) begin
      if (div_cnt_reg >= DIV_SEL - 8'h01) begin
        div_cnt_reg <= 8'h00;
        insn_tick   <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
        insn_tick   <= 1'b0;
      end
    end else begin
      div_cnt_reg <= 8'h00;
      insn_tick   <= 1'b0;
    end
  end

  // ==========================================================
  // oscillator enables and clock select, all registered
  opm_state_type st;
  logic          slow_src; // slow rc is feeding the system clock
  assign st       = state_reg;
  assign slow_src = (st == OPM_ST_SLOW) ||
                    (st == OPM_ST_GREEN && green_from_slow_reg);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fast_osc_en <= 1'b1;
      rtc_xtal_en <= 1'b1;
      slow_osc_en <= 1'b1;
      sysclk_sel  <= OPM_SRC_FAST;
      cpu_run     <= 1'b1;
    end else begin
      // fast osc stops on powerdown, or on the halt bit once it no
      // longer feeds the system clock; in normal the halt bit waits
      // for the halt state so the cpu never runs on a dead source
      fast_osc_en <= !(st == OPM_ST_PDOWN || st == OPM_ST_HALT) &&
                     !(fast_osc_halt_reg && slow_src);
      // rtc crystal only follows powerdown, not the halt bit
      rtc_xtal_en <= (OSC_KIND == OPM_OSC_IRTC) &&
                     (st != OPM_ST_PDOWN);
      slow_osc_en <= !(st == OPM_ST_PDOWN || st == OPM_ST_HALT);
      if (slow_src) begin
        sysclk_sel <= OPM_SRC_SLOW;
      end else if (st == OPM_ST_PDOWN || st == OPM_ST_HALT) begin
        sysclk_sel <= OPM_SRC_NONE;
      end else begin
        sysclk_sel <= OPM_SRC_FAST;
      end
      cpu_run <= (st == OPM_ST_NORMAL || st == OPM_ST_SLOW);
    end
  end

  // ==========================================================
  // peripheral run gates, off in powerdown
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      basic_timer_en    <= 1'b0;
      ext_timer_zero_en <= 1'b0;
      adc_en            <= 1'b0;
      pwm_en            <= 1'b0;
    end else begin
      basic_timer_en    <= timer_ctrl_reg[`OPM_BT_RUN_BIT] &&
                           !is_off(st);
      ext_timer_zero_en <= timer_ctrl_reg[`OPM_ET0_RUN_BIT] &&
                           !is_off(st);
      adc_en            <= timer_ctrl_reg[`OPM_ADC_RUN_BIT] &&
                           !is_off(st);
      pwm_en            <= timer_ctrl_reg[`OPM_ET0_RUN_BIT] &&
                           !is_off(st);
    end
  end

  // states that gate peripherals: no clock, or the warm-up wait
  function automatic logic is_off(input opm_state_type s);
    is_off = (s == OPM_ST_PDOWN) || (s == OPM_ST_HALT) ||
             (s == OPM_ST_WARM);
  endfunction

  // ==========================================================
  // axi read channel; wake enable reads zero, it is write only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_hit(s_axi_araddr) ? 2'b00 : 2'b11;
        unique case (s_axi_araddr)
          `OPM_OSC_MODE_ADDR: s_axi_rdata <= {27'h000_0000,
              green_request_reg, powerdown_request_reg,
              slow_clock_select_reg, fast_osc_halt_reg, 1'b0};
          `OPM_STATUS_ADDR:   s_axi_rdata <= {28'h000_0000,
              green_from_slow_reg, state_reg};
          `OPM_TIMER_CTRL_ADDR: s_axi_rdata <= {29'h0000_0000,
              timer_ctrl_reg};
          default:            s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // opm_ctrl

//--- rtl/opm_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef OPM_REGS_SVH
`define OPM_REGS_SVH

// ==========================================================
// register byte addresses
`define OPM_PORT1_WAKE_ENABLE_ADDR 8'hc0
`define OPM_OSC_MODE_ADDR          8'hca
`define OPM_STATUS_ADDR            8'hd0
`define OPM_TIMER_CTRL_ADDR        8'hd4

// ==========================================================
// oscillator mode register fields
`define OPM_FAST_HALT_BIT   1
`define OPM_SLOW_SEL_BIT    2
`define OPM_PD_REQ_BIT      3
`define OPM_GREEN_REQ_BIT   4

// timer control register fields
`define OPM_BT_RUN_BIT      0
`define OPM_ET0_RUN_BIT     1
`define OPM_ADC_RUN_BIT     2

// ==========================================================
// reset values
`define OPM_P1W_RESET       8'h00
`define OPM_OSC_RESET       8'h00

// ==========================================================
// warm-up counts in fast clock periods
`define OPM_WARM_XTAL       12'h800
`define OPM_WARM_RC         12'h020

// slowest prescale option
`define OPM_DIV_MAX         8'h80

`endif

//--- rtl/opm_pkg.sv
// types for the operating mode and wake control block
package opm_pkg;

  // cpu mode field encoding
  typedef enum logic [1:0] {
    OPM_CPU_NORMAL = 2'b00,
    OPM_CPU_PDOWN  = 2'b01,
    OPM_CPU_GREEN  = 2'b10,
    OPM_CPU_RSVD   = 2'b11
  } opm_cpu_mode_type;

  // controller state
  typedef enum logic [2:0] {
    OPM_ST_NORMAL = 3'b000,
    OPM_ST_SLOW   = 3'b001,
    OPM_ST_PDOWN  = 3'b010,
    OPM_ST_WARM   = 3'b011,
    OPM_ST_GREEN  = 3'b100,
    OPM_ST_HALT   = 3'b101
  } opm_state_type;

  // high clock build option
  typedef enum logic [1:0] {
    OPM_OSC_XTAL  = 2'b00,
    OPM_OSC_RC    = 2'b01,
    OPM_OSC_IRC   = 2'b10,
    OPM_OSC_IRTC  = 2'b11
  } opm_osc_kind_type;

  // clock source for the system clock mux
  typedef enum logic [1:0] {
    OPM_SRC_NONE = 2'b00,
    OPM_SRC_FAST = 2'b01,
    OPM_SRC_SLOW = 2'b10
  } opm_src_type;

endpackage

//--- testbench/opm_ctrl_props.sv
// concurrent checks on the operating mode block ports
`timescale 1ns/1ns
module opm_ctrl_props
  import opm_pkg::*;
#(
  parameter opm_osc_kind_type OSC_KIND = OPM_OSC_XTAL, // build option
  parameter logic [7:0]       DIV_SEL  = 8'h04         // prescale
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        insn_boundary,
  input wire logic        fast_osc_en,
  input wire logic        slow_osc_en,
  input wire logic [1:0]  sysclk_sel,
  input wire logic        cpu_run,
  input wire logic        insn_tick,
  input wire logic        basic_timer_en,
  input wire logic        ext_timer_zero_en,
  input wire logic        adc_en
);
  // ==========================================================
  // one clock domain, reset masks every check
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // oscillators and clock source
  a_pd_all_off: assert property (!slow_osc_en && !fast_osc_en |->
    !cpu_run && !basic_timer_en && !ext_timer_zero_en && !adc_en)
    else $error("cpu or peripheral active with oscillators off");
  a_run_clk: assert property (cpu_run |-> sysclk_sel != 2'h0)
    else $error("cpu runs without a clock source");
  a_slow_src: assert property (sysclk_sel == 2'h2 |-> slow_osc_en)
    else $error("slow source chosen while slow osc off");
  a_fast_src: assert property (sysclk_sel == 2'h1 |-> fast_osc_en)
    else $error("fast source chosen while fast osc off");

  // ==========================================================
  // instruction pacing; a divide of four leaves three quiet cycles
  a_tick_gap: assert property (insn_tick |=> !insn_tick [*3])
    else $error("instruction ticks closer than the prescale");
  a_tick_run: assert property (insn_tick |-> $past(cpu_run))
    else $error("instruction tick while cpu halted");
  a_mode_bound: assert property ($fell(cpu_run) |->
    $past(insn_boundary) || $past(insn_boundary, 2))
    else $error("cpu halted away from an instruction boundary");

  // ==========================================================
  // bus answers stand until taken
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
endmodule // opm_ctrl_props

bind opm_ctrl opm_ctrl_props #(.OSC_KIND(OSC_KIND), .DIV_SEL(DIV_SEL))
  i_props (.mclk, .sys_rst, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .insn_boundary, .fast_osc_en, .slow_osc_en,
  .sysclk_sel, .cpu_run, .insn_tick, .basic_timer_en, .ext_timer_zero_en,
  .adc_en);

//--- testbench/opm_host_model.sv
// far side model: instruction boundaries, fast ticks, timer, port1 pins
`timescale 1ns/1ns
module opm_host_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       fast_osc_en,
  input  wire logic       basic_timer_en,
  input  wire logic [7:0] pin_level,
  output logic [7:0]      port1_pins,
  output logic            basic_timer_ovf,
  output logic            insn_boundary,
  output logic            fast_ticks
);
  logic [3:0] phase_reg; // free running phase count

  // ==========================================================
  // boundary every fourth clock so mode writes wait a little;
  // fast ticks only while the oscillator really runs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase_reg       <= 4'h0;
      insn_boundary   <= 1'h0;
      fast_ticks      <= 1'h0;
      basic_timer_ovf <= 1'h0;
      port1_pins      <= 8'h00;
    end else begin
      phase_reg       <= phase_reg + 4'h1;
      insn_boundary   <= phase_reg[1:0] == 2'h3;
      fast_ticks      <= fast_osc_en & phase_reg[0];
      basic_timer_ovf <= basic_timer_en && phase_reg == 4'hf;
      port1_pins      <= pin_level;
    end
  end
endmodule // opm_host_model

//--- testbench/operating_mode_wakeup_control_tb.sv
// self-checking bench for the operating mode and wake block
`timescale 1ns/1ns
module operating_mode_wakeup_control_tb;
  // ==========================================================
  // signals
  logic        mclk, sys_rst, s_axi_awvalid, s_axi_awready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_level, port1_pins;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sysclk_sel;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        basic_timer_ovf, insn_boundary, fast_ticks, fast_osc_en;
  logic        rtc_xtal_en, slow_osc_en, cpu_run, insn_tick, pwm_en;
  logic        basic_timer_en, ext_timer_zero_en, adc_en;
  int          err_count, checked, cycles;

  // rc build option keeps the warm-up short
  opm_ctrl #(.OSC_KIND(opm_pkg::OPM_OSC_RC)) i_dut (.mclk, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port1_pins, .basic_timer_ovf, .insn_boundary,
    .fast_ticks, .fast_osc_en, .rtc_xtal_en, .slow_osc_en, .sysclk_sel,
    .cpu_run, .insn_tick, .basic_timer_en, .ext_timer_zero_en, .adc_en,
    .pwm_en);
  opm_host_model i_host (.mclk, .sys_rst, .fast_osc_en, .basic_timer_en,
    .pin_level, .port1_pins, .basic_timer_ovf, .insn_boundary, .fast_ticks);

  // ==========================================================
  // clock and hang guard
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // write: address and data together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'h0;
    chk("wresp", {s_axi_bvalid, s_axi_bresp}, 3'h4);
  endtask
  // read and compare data and response
  task automatic rdr(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'h0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", {s_axi_rvalid, s_axi_rresp}, {1'h1, r});
  endtask
  // wait for the cpu run level under a bound
  task automatic wait_run(input logic v, input int lim);
    int n;
    n = 0;
    while (cpu_run !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk("cpu_run", cpu_run, v);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("fast_en", fast_osc_en, 1'h1);
    chk("clk_sel", sysclk_sel, 2'h1);
    rdr(8'hc0, 32'h0000_0000, 2'h0);
    rdr(8'hca, 32'h0000_0000, 2'h0);
    rdr(8'h44, 32'h0000_0000, 2'h3);
    $display("test reset done");
  endtask
  task automatic t_slow();
    int n;
    n = 0;
    wr(8'hca, 32'h0000_0004);
    cyc(8);
    chk("clk_sel", sysclk_sel, 2'h2);
    chk("fast_en", fast_osc_en, 1'h1);
    chk("rtc_en", rtc_xtal_en, 1'h0);
    rdr(8'hd0, 32'h0000_0001, 2'h0);
    repeat (40) begin
      @(posedge mclk);
      if (insn_tick === 1'h1) n++;
    end
    chk("ticks", n, 40 / 4);
    wr(8'hca, 32'h0000_0006);
    cyc(8);
    chk("fast_en", fast_osc_en, 1'h0);
    chk("slow_en", slow_osc_en, 1'h1);
    chk("cpu_run", cpu_run, 1'h1);
    $display("test slow done");
  endtask
  task automatic t_green();
    wr(8'hd4, 32'h0000_0007);
    cyc(20);
    chk("cpu_run", cpu_run, 1'h1);
    wr(8'hca, 32'h0000_0016);
    wait_run(1'h0, 12);
    chk("clk_sel", sysclk_sel, 2'h2);
    chk("pwm_en", pwm_en, 1'h1);
    chk("bt_en", basic_timer_en, 1'h1);
    chk("et0_en", ext_timer_zero_en, 1'h1);
    wait_run(1'h1, 24);
    chk("clk_sel", sysclk_sel, 2'h2);
    rdr(8'hca, 32'h0000_0006, 2'h0);
    $display("test green done");
  endtask
  task automatic t_pdown();
    wr(8'hc0, 32'h0000_0008);
    rdr(8'hc0, 32'h0000_0000, 2'h0);
    wr(8'hca, 32'h0000_000c);
    wait_run(1'h0, 12);
    chk("osc_en", {fast_osc_en, slow_osc_en, sysclk_sel}, 4'h0);
    chk("per_en", {basic_timer_en, ext_timer_zero_en, adc_en}, 3'h0);
    pin_level <= 8'h01;
    cyc(20);
    chk("cpu_run", cpu_run, 1'h0);
    pin_level <= 8'h09;
    cyc(40);
    chk("cpu_run", cpu_run, 1'h0);
    wait_run(1'h1, 100);
    chk("clk_sel", sysclk_sel, 2'h1);
    rdr(8'hca, 32'h0000_0000, 2'h0);
    $display("test power down done");
  endtask
  task automatic t_halt();
    wr(8'hca, 32'h0000_0002);
    wait_run(1'h0, 12);
    chk("clk_sel", sysclk_sel, 2'h0);
    pin_level <= 8'h01;
    wait_run(1'h1, 200);
    $display("test halt done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    mclk          = 1'h0;
    sys_rst       = 1'h1;
    err_count     = 0;
    checked       = 0;
    cycles        = 0;
    pin_level     = 8'h00;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0000_0000;
    s_axi_wstrb   = 4'hf;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid  = 1'h0;
    s_axi_bready  = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready  = 1'h0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    t_reset();
    t_slow();
    t_green();
    t_pdown();
    t_halt();
    test_done();
  end
endmodule // operating_mode_wakeup_control_tb
